// ---- design/dss_sel_regs.vh ----
/*
 * Register offsets, field positions, reset values and timing counts
 * of the drive setting bank selector.
 * Assumes a 32-bit APB slave with byte addresses on 12 bits.
 */
`ifndef DSS_SEL_REGS_VH
`define DSS_SEL_REGS_VH

// Register byte offsets
`define DSS_OFF_FILTER     12'h000
`define DSS_OFF_COUNT      12'h004
`define DSS_OFF_SELSRC     12'h008
`define DSS_OFF_MOTOR      12'h00C
`define DSS_OFF_COPY       12'h010
`define DSS_OFF_STATUS     12'h014
`define DSS_OFF_SAVE       12'h018
// Settings window: 0x080..0x0FC, bank in addr[6:5], word in addr[4:2]
`define DSS_SET_BASE_HI    5'h01

// Field positions
`define DSS_COPY_TGT_LSB   4
`define DSS_COPY_START     8
`define DSS_ST_SEL_LSB     4
`define DSS_ST_PENDING     8
`define DSS_ST_COPY_BUSY   9
`define DSS_ST_SAVE_BUSY   10
`define DSS_ST_SWITCHING   11

// Reset values and codes
`define DSS_COUNT_RESET    3'h1
`define DSS_FILTER_READY   8'h00
`define DSS_FILTER_DATASET 8'h0F
`define DSS_SELSRC_RESET   32'h0000_0000
`define DSS_MOTOR_RESET    16'h0000

// Timing
`define DSS_SWITCH_MS      50
`define DSS_CLK_KHZ        100000
`define DSS_SWITCH_CYCLES  (`DSS_SWITCH_MS * `DSS_CLK_KHZ)

`endif

// ---- design/dss_sel.v ----
/*
 * Drive setting bank selector: four banks of switchable settings,
 * bank count, per command set select sources, motor interlock,
 * bank copy and a non-volatile store stream, all behind APB.
 * Assumes ctrl_bits, cmd_set and the drive state pins are asynchronous
 * and that an external store accepts one nv word per cycle.
 * Assumes the master drives APB on sys_clk; pready follows clk_en, so
 * a frozen block stretches the access phase until enable returns.
 * Assumes SWITCH_CYCLES matches the clock rate; the default gives
 * the timed switchover length at a 100 MHz sys_clk.
 * The store stream is outbound only; nothing is reloaded on reset.
 * Pin changes reach the logic two enabled edges after they occur.
 */
// The placing of the registers and the APB slave port were chosen for this implementation.
`include "dss_sel_regs.vh"

module dss_sel #(
    parameter SWITCH_CYCLES = `DSS_SWITCH_CYCLES
) (
    // Clock, reset, enable
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        clk_en,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    // Control command pins
    input  wire [7:0]  ctrl_bits,
    input  wire [1:0]  cmd_set,
    input  wire        drive_running,
    input  wire        drive_ready,
    // Effective bank and its settings
    output reg  [1:0]  effective_bank,
    output reg         switch_busy,
    input  wire [2:0]  set_rd_addr,
    output reg  [31:0] set_rd_data,
    // Non-volatile store stream
    output reg         nv_wr_valid,
    output reg  [4:0]  nv_wr_addr,
    output reg  [31:0] nv_wr_data
);

    // Switchover states
    localparam ST_IDLE  = 1'b0;
    localparam ST_TIMED = 1'b1;

    // Timer load: the bank moves on the edge at which the timer reads zero
    localparam [31:0] SWITCH_LOAD = SWITCH_CYCLES - 1;

    // Pin synchronisers
    reg  [7:0]  ctrl_m_r;
    reg  [7:0]  ctrl_s_r;
    reg  [1:0]  cset_m_r;
    reg  [1:0]  cset_s_r;
    reg  [1:0]  drv_m_r;
    reg  [1:0]  drv_s_r;

    // Registers
    reg  [7:0]  filter_r;
    reg  [2:0]  count_r;
    reg  [31:0] selsrc_r;
    reg  [15:0] motor_r;
    reg  [1:0]  copy_src_r;
    reg  [1:0]  copy_tgt_r;
    reg         copy_busy_r;
    reg  [2:0]  copy_idx_r;
    reg         save_busy_r;
    reg  [4:0]  save_idx_r;
    // Settings memory: 32 words, index {bank, word}
    reg  [31:0] bank_mem_r [0:31];
    reg         state_r;
    reg  [1:0]  target_r;
    reg  [31:0] timer_r;

    // Decode and selection nets
    wire        wr_en;
    wire        rd_en;
    wire        set_hit;
    wire [4:0]  set_idx;
    wire [5:0]  src_pair;
    wire [1:0]  sel_bank;
    wire        want;
    wire        same_motor;
    wire        drv_run;
    wire        drv_rdy;
    integer     i;

    // Pick one control bit by its source number
    // Used for both select bits of the active pair
    function pick_bit;
        input [7:0] bits;
        input [2:0] idx;
        begin
            pick_bit = bits[idx];
        end
    endfunction

    // Motor number of one bank
    // Four bits per bank, bank b at bits 4b+3 down to 4b
    function [3:0] motor_of;
        input [15:0] m;
        input [1:0]  b;
        begin
            motor_of = m[{b, 2'b00} +: 4];
        end
    endfunction

    // APB decode; zero wait states while enabled
    // A low clk_en holds pready low and blocks every write
    assign pready  = clk_en;
    assign wr_en   = psel & penable & pwrite & clk_en;
    assign rd_en   = psel & penable & ~pwrite;
    assign set_hit = (paddr[11:7] == `DSS_SET_BASE_HI);
    assign set_idx = paddr[6:2];
    assign drv_run = drv_s_r[0];
    assign drv_rdy = drv_s_r[1];

    // Source pair of the active command set
    assign src_pair = selsrc_r[{cset_s_r, 3'b000} +: 6];
    // Bank index from the two select bits
    assign sel_bank = {pick_bit(ctrl_s_r, src_pair[5:3]),
                       pick_bit(ctrl_s_r, src_pair[2:0])};
    // Out-of-range selection is never taken up
    // A selection equal to the effective bank is no request
    assign want = (sel_bank != effective_bank) &&
                  ({1'b0, sel_bank} < count_r);
    // All banks belong to one motor
    assign same_motor = (motor_of(motor_r, 2'd0) == motor_of(motor_r, 2'd1)) &&
                        (motor_of(motor_r, 2'd0) == motor_of(motor_r, 2'd2)) &&
                        (motor_of(motor_r, 2'd0) == motor_of(motor_r, 2'd3));

    // Two-flop synchronisers for all pin inputs
    // Only the second stage is read; the first may be metastable
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_m_r <= 8'h00;
            ctrl_s_r <= 8'h00;
            cset_m_r <= 2'h0;
            cset_s_r <= 2'h0;
            drv_m_r  <= 2'h0;
            drv_s_r  <= 2'h0;
        end else if (clk_en) begin
            ctrl_m_r <= ctrl_bits;
            ctrl_s_r <= ctrl_m_r;
            cset_m_r <= cmd_set;
            cset_s_r <= cset_m_r;
            drv_m_r  <= {drive_ready, drive_running};
            drv_s_r  <= drv_m_r;
        end
    end

    // Configuration registers
    // The filter stays as written; software returns it to ready
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            filter_r <= `DSS_FILTER_READY;
            count_r  <= `DSS_COUNT_RESET;
            selsrc_r <= `DSS_SELSRC_RESET;
            motor_r  <= `DSS_MOTOR_RESET;
        end else if (clk_en && wr_en) begin
            case (paddr)
                `DSS_OFF_FILTER: filter_r <= pwdata[7:0];
                `DSS_OFF_COUNT: begin
                    // Count changes only in dataset commissioning
                    if (filter_r == `DSS_FILTER_DATASET &&
                        pwdata[2:0] != 3'd0 && pwdata[31:3] == 29'd0 &&
                        pwdata[2:0] <= 3'd4) begin
                        count_r <= pwdata[2:0];
                    end
                end
                `DSS_OFF_SELSRC: selsrc_r <= pwdata & 32'h3F3F_3F3F;
                `DSS_OFF_MOTOR: motor_r <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Settings memory, bank copy and store stream
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            // Every word cleared so reads after reset are defined
            for (i = 0; i < 32; i = i + 1) begin
                bank_mem_r[i] <= 32'h0000_0000;
            end
            copy_src_r  <= 2'h0;
            copy_tgt_r  <= 2'h0;
            copy_busy_r <= 1'b0;
            copy_idx_r  <= 3'h0;
            save_busy_r <= 1'b0;
            save_idx_r  <= 5'h00;
            nv_wr_valid <= 1'b0;
            nv_wr_addr  <= 5'h00;
            nv_wr_data  <= 32'h0000_0000;
            set_rd_data <= 32'h0000_0000;
        end else if (clk_en) begin
            // Software writes one word of one bank
            if (wr_en && set_hit && !copy_busy_r) begin
                bank_mem_r[set_idx] <= pwdata;
            end
            // Start a copy; ignored while a copy or a store runs, so the
            // store stream never pauses or carries half-copied words
            if (wr_en && paddr == `DSS_OFF_COPY && pwdata[`DSS_COPY_START] &&
                !copy_busy_r && !save_busy_r) begin
                copy_src_r  <= pwdata[1:0];
                copy_tgt_r  <= pwdata[`DSS_COPY_TGT_LSB +: 2];
                copy_busy_r <= 1'b1;
                copy_idx_r  <= 3'h0;
            end else if (copy_busy_r) begin
                // One word per cycle, all eight words of the bank
                bank_mem_r[{copy_tgt_r, copy_idx_r}] <=
                    bank_mem_r[{copy_src_r, copy_idx_r}];
                copy_idx_r <= copy_idx_r + 3'd1;
                if (copy_idx_r == 3'd7) begin
                    copy_busy_r <= 1'b0;
                end
            end
            // Store request waits until any copy has finished
            // Valid, address and data are registered together, one word a cycle
            if (wr_en && paddr == `DSS_OFF_SAVE && pwdata[0] && !save_busy_r) begin
                save_busy_r <= 1'b1;
                save_idx_r  <= 5'h00;
                nv_wr_valid <= 1'b0;
            end else if (save_busy_r && !copy_busy_r) begin
                nv_wr_valid <= 1'b1;
                nv_wr_addr  <= save_idx_r;
                nv_wr_data  <= bank_mem_r[save_idx_r];
                save_idx_r  <= save_idx_r + 5'd1;
                if (save_idx_r == 5'd31) begin
                    save_busy_r <= 1'b0;
                end
            end else begin
                nv_wr_valid <= 1'b0;
            end
            // Settings of the effective bank for the drive
            // Read port follows the effective bank one cycle later
            set_rd_data <= bank_mem_r[{effective_bank, set_rd_addr}];
        end
    end

    // Bank switchover with motor interlock
    // A timed switch runs to its end even if the drive state changes
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r        <= ST_IDLE;
            effective_bank <= 2'h0;
            target_r       <= 2'h0;
            timer_r        <= 32'h0000_0000;
            switch_busy    <= 1'b0;
        end else if (clk_en) begin
            case (state_r)
                ST_IDLE: begin
                    // Selection is looked at anew on every enabled edge
                    if (want && same_motor) begin
                        // All four banks on one motor: switch at once, even while running
                        effective_bank <= sel_bank;
                    end else if (want && drv_rdy && !drv_run) begin
                        // Banks on more than one motor: only ready with motor off
                        target_r    <= sel_bank;
                        timer_r     <= SWITCH_LOAD;
                        switch_busy <= 1'b1;
                        state_r     <= ST_TIMED;
                    end
                    // Otherwise the request stays pending
                end
                ST_TIMED: begin
                    // Selection changes are not seen until the timer runs out
                    if (timer_r == 32'h0000_0000) begin
                        effective_bank <= target_r;
                        switch_busy    <= 1'b0;
                        state_r        <= ST_IDLE;
                    end else begin
                        timer_r <= timer_r - 32'd1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // APB read mux and error on unmapped address
    // Read data is zero outside the access phase of a read
    always @* begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        if (psel && penable) begin
            if (set_hit) begin
                if (rd_en) begin
                    prdata = bank_mem_r[set_idx];
                end
            end else begin
                case (paddr)
                    `DSS_OFF_FILTER: prdata = {24'h00_0000, filter_r};
                    `DSS_OFF_COUNT:  prdata = {29'h0000_0000, count_r};
                    `DSS_OFF_SELSRC: prdata = selsrc_r;
                    `DSS_OFF_MOTOR:  prdata = {16'h0000, motor_r};
                    `DSS_OFF_COPY: begin
                        prdata[1:0] = copy_src_r;
                        prdata[`DSS_COPY_TGT_LSB +: 2] = copy_tgt_r;
                        prdata[`DSS_COPY_START] = copy_busy_r;
                    end
                    `DSS_OFF_STATUS: begin
                        prdata[1:0] = effective_bank;
                        prdata[`DSS_ST_SEL_LSB +: 2] = sel_bank;
                        prdata[`DSS_ST_PENDING] = want;
                        prdata[`DSS_ST_COPY_BUSY] = copy_busy_r;
                        prdata[`DSS_ST_SAVE_BUSY] = save_busy_r;
                        prdata[`DSS_ST_SWITCHING] = switch_busy;
                        // Status is read-only; a write is refused with an error
                        if (pwrite) begin
                            pslverr = 1'b1;
                        end
                    end
                    `DSS_OFF_SAVE:   prdata = {31'h0000_0000, save_busy_r};
                    default:         pslverr = 1'b1;
                endcase
                if (!rd_en) begin
                    prdata = 32'h0000_0000;
                end
            end
        end
    end

endmodule // dss_sel

// ---- verification/dss_sel_asserts.sv ----
/* Port checker for the drive setting bank selector.
   Bound to dss_sel; sees its ports only, one clock domain. */
module dss_sel_chk #(
    parameter int SWITCH_CYCLES = 20
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pslverr,
    // Bank and store outputs
    input wire logic [1:0]  effective_bank,
    input wire logic        switch_busy,
    input wire logic        nv_wr_valid,
    input wire logic [4:0]  nv_wr_addr
);
    // Enabled cycles spent in a timed switchover
    logic [31:0] busy_cnt_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !switch_busy)
            busy_cnt_r <= 32'h0;
        else if (clk_en)
            busy_cnt_r <= busy_cnt_r + 32'h1;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    status_ro_a: assert property (psel && penable && pwrite && paddr == 12'h014 |-> pslverr)
        else $error("status write not refused");
    bank_reset_a: assert property (disable iff (1'b0) !rst_n |=> effective_bank == 2'h0)
        else $error("bank not zero after reset");
    busy_holds_bank_a: assert property (switch_busy ##1 switch_busy |-> $stable(effective_bank))
        else $error("bank moved during timed switch");
    switch_len_a: assert property ($fell(switch_busy) |-> busy_cnt_r == SWITCH_CYCLES)
        else $error("timed switch length wrong");
    switch_ends_a: assert property ($rose(switch_busy) |-> ##[1:1000] !switch_busy)
        else $error("timed switch never ends");
    fall_moves_bank_a: assert property ($fell(switch_busy) |-> $changed(effective_bank))
        else $error("bank not changed at end of switch");
    rise_keeps_bank_a: assert property ($rose(switch_busy) |-> $stable(effective_bank))
        else $error("bank changed at start of timed switch");
    nv_addr_step_a: assert property (nv_wr_valid && $past(nv_wr_valid)
        |-> nv_wr_addr == $past(nv_wr_addr) + 5'h01)
        else $error("store address not stepping");
    nv_start_a: assert property ($rose(nv_wr_valid) |-> nv_wr_addr == 5'h00)
        else $error("store not starting at word zero");
endmodule // dss_sel_chk

bind dss_sel dss_sel_chk #(.SWITCH_CYCLES(SWITCH_CYCLES)) u_chk (.sys_clk, .rst_n, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pslverr, .effective_bank, .switch_busy,
    .nv_wr_valid, .nv_wr_addr);

// ---- verification/dss_cmd_src.sv ----
/* Control command source: select bits, command set, drive state.
   Driven by the bench through its drive task, entered after an edge. */
module dss_cmd_src (
    // Clock
    input wire logic  sys_clk,
    // Command outputs
    output logic [7:0] ctrl_bits,
    output logic [1:0] cmd_set,
    output logic       drive_running,
    output logic       drive_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle: motor off and ready
    initial begin
        ctrl_bits = 8'h00;
        cmd_set = 2'h0;
        drive_running = 1'b0;
        drive_ready = 1'b1;
    end
    // Apply a new command just after a rising edge
    task automatic drive(input logic [7:0] b, input logic [1:0] s, input logic run, input logic rdy);
        @(posedge sys_clk);
        ctrl_bits <= b;
        cmd_set <= s;
        drive_running <= run;
        drive_ready <= rdy;
    endtask
endmodule // dss_cmd_src

// ---- verification/dss_sel_tb.sv ----
/* Self-checking bench of the drive setting bank selector.
   Short timed switchover; command source model on the far side. */
module dss_sel_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SW = 20;
    logic        sys_clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, set_rd_data, nv_wr_data, q, s;
    logic [7:0]  ctrl_bits, b;
    logic [1:0]  cmd_set, effective_bank, x;
    logic        drive_running, drive_ready, switch_busy, nv_wr_valid;
    logic [2:0]  set_rd_addr, w;
    logic [4:0]  nv_wr_addr;
    logic [31:0] mem [0:31];
    logic [31:0] seed = 32'h5B;
    int          num_errors, n_tests, nv_cnt, k;

    dss_sel #(.SWITCH_CYCLES(SW)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ctrl_bits(ctrl_bits), .cmd_set(cmd_set), .drive_running(drive_running),
        .drive_ready(drive_ready), .effective_bank(effective_bank),
        .switch_busy(switch_busy), .set_rd_addr(set_rd_addr), .set_rd_data(set_rd_data),
        .nv_wr_valid(nv_wr_valid), .nv_wr_addr(nv_wr_addr), .nv_wr_data(nv_wr_data));
    dss_cmd_src u_cmd (.sys_clk(sys_clk), .ctrl_bits(ctrl_bits), .cmd_set(cmd_set),
        .drive_running(drive_running), .drive_ready(drive_ready));

    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Bank named by the select bits under one source pair
    function automatic logic [1:0] pick(logic [7:0] bits, logic [5:0] src);
        return {bits[src[5:3]], bits[src[2:0]]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    // One APB transfer, entered just after an edge
    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        chk({31'h0, pready}, 32'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic set_count(input logic [31:0] n);
        wr(12'h000, 32'h0F);
        wr(12'h004, n);
        wr(12'h000, 32'h0);
    endtask
    task automatic wait_bank(input logic [1:0] exp);
        k = 0;
        while (effective_bank !== exp && k < 40) begin
            @(posedge sys_clk);
            k++;
        end
        chk(effective_bank, exp);
    endtask
    task automatic chk_mem();
        for (int i = 0; i < 32; i++) rd(12'h080 + 12'(i * 4), mem[i]);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Store stream against the settings mirror
    always @(posedge sys_clk) begin
        if (nv_wr_valid === 1'b1) begin
            nv_cnt++;
            chk(nv_wr_data, mem[nv_wr_addr]);
        end
    end
    // Watchdog
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, set_rd_addr} = '0;
        clk_en = 1'b1;
        for (int i = 0; i < 32; i++) mem[i] = 32'h0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(12'h004, 32'h1);
        rd(12'h014, 32'h0);
        wr(12'h014, 32'hF);
        chk(e, 1'b1);
        rd(12'h020, 32'h0);
        chk(e, 1'b1);
        wr(12'h004, 32'h4);
        rd(12'h004, 32'h1);
        set_count(32'h5);
        rd(12'h004, 32'h1);
        set_count(32'h4);
        rd(12'h004, 32'h4);
        for (int i = 0; i < 32; i++) begin
            mem[i] = rnd();
            wr(12'h080 + 12'(i * 4), mem[i]);
        end
        chk_mem();
        wr(12'h010, 32'h120);
        k = 0;
        do begin
            apb(1'b0, 12'h014, 32'h0);
            k++;
        end while (q[9] !== 1'b0 && k < 20);
        chk(q[9], 1'b0);
        for (int i = 0; i < 8; i++) mem[16 + i] = mem[i];
        chk_mem();
        s = rnd() & 32'h3F3F3F3F;
        wr(12'h008, s);
        for (int c = 0; c < 4; c++) begin
            b = 8'(rnd());
            w = 3'(rnd());
            u_cmd.drive(b, 2'(c), 1'b1, 1'b0);
            x = pick(b, s[8 * c +: 6]);
            wait_bank(x);
            set_rd_addr <= w;
            repeat (3) @(posedge sys_clk);
            chk(set_rd_data, mem[{x, w}]);
        end
        wr(12'h008, 32'h08);
        u_cmd.drive(8'h01, 2'h0, 1'b1, 1'b0);
        wait_bank(2'h1);
        set_count(32'h2);
        u_cmd.drive(8'h02, 2'h0, 1'b1, 1'b0);
        repeat (10) @(posedge sys_clk);
        chk(effective_bank, 2'h1);
        wr(12'h00C, 32'h3210);
        rd(12'h00C, 32'h3210);
        u_cmd.drive(8'h02, 2'h0, 1'b1, 1'b0);
        set_count(32'h4);
        repeat (10) @(posedge sys_clk);
        chk(effective_bank, 2'h1);
        apb(1'b0, 12'h014, 32'h0);
        chk(q[8], 1'b1);
        u_cmd.drive(8'h02, 2'h0, 1'b0, 1'b1);
        k = 0;
        while (switch_busy !== 1'b1 && k < 20) begin
            @(posedge sys_clk);
            k++;
        end
        chk(switch_busy, 1'b1);
        k = 0;
        while (effective_bank !== 2'h2 && k < 100) begin
            @(posedge sys_clk);
            k++;
        end
        chk(32'(k > SW - 3 && k < SW + 3), 32'h1);
        rd(12'h014, 32'h22);
        // Frozen enable: a switch to bank 0 must wait for clk_en
        clk_en <= 1'b0;
        u_cmd.drive(8'h00, 2'h0, 1'b0, 1'b1);
        repeat (8) @(posedge sys_clk);
        chk(switch_busy, 1'b0);
        chk(effective_bank, 2'h2);
        clk_en <= 1'b1;
        wait_bank(2'h0);
        wr(12'h018, 32'h1);
        repeat (50) @(posedge sys_clk);
        chk(nv_cnt, 32);
        // Reset in mid-run brings back the defaults
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(12'h004, 32'h1);
        rd(12'h014, 32'h0);
        report_and_stop();
    end
endmodule // dss_sel_tb
